// ### core/cdtwp_port.sv
/*
 * command-driven two-wire port, master or slave that never matches its own address, on apb.
 * assumes open-drain pads outside: oe high pulls the line low.
 */
`timescale 1ns/100ps
`include "cdtwp_defs.svh"

module cdtwp_port
    import cdtwp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        primary_data_pin_i,
    input  wire logic        primary_clock_pin_i,
    input  wire logic        alt_data_pin_i,
    input  wire logic        alt_clock_pin_i,
    output cdtwp_drv_t       primary_drv,
    output cdtwp_drv_t       alt_drv
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_BIT, ST_STOP
    } cdtwp_st_t;

    localparam logic [15:0] LO_Q = 16'(`CDTWP_LO_QTR);
    localparam logic [15:0] HI_Q = 16'(`CDTWP_HI_QTR);

    cdtwp_st_t   st_r;
    logic [15:0] std_r;
    logic        rate_r, role_r, busy_r;
    logic [7:0]  tx_r, rx_r, own_r;
    logic [3:0]  cmd_r;
    logic [3:0]  nbit_r;
    logic [8:0]  sh_r;
    logic        rxmode_r, rxnext_r;
    logic [1:0]  ph_r;
    logic [15:0] cnt_r;
    logic        tick;
    logic        sda_lo_r, scl_lo_r;
    logic        mack_r;
    logic [1:0]  sda_s_r, scl_s_r;
    logic        sda_in, scl_in, scl_d_r;
    logic        wr_cmd, wr_std, rd_ok, soft_rst;

    // apb: zero wait states, unmapped reads give zero with an error
    assign pready  = 1'b1;
    assign rd_ok   = paddr == `CDTWP_OFF_CMD || paddr == `CDTWP_OFF_STD;
    assign pslverr = psel & penable & ~rd_ok;
    assign wr_cmd  = psel & penable & pwrite & paddr == `CDTWP_OFF_CMD;
    assign wr_std  = psel & penable & pwrite & paddr == `CDTWP_OFF_STD;
    assign soft_rst = wr_cmd & pwdata[`CDTWP_BIT_RESET];

    // read data registered from state; command and reset read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0;
        end else if (psel & ~penable) begin
            if (paddr == `CDTWP_OFF_CMD)
                prdata <= {21'h0, rate_r, role_r, busy_r,
                           rx_r};
            else if (paddr == `CDTWP_OFF_STD)
                prdata <= {16'h0, std_r};
            else
                prdata <= 32'h0;
        end
    end

    // standard control register, only pin select acts here
    always_ff @(posedge clk) begin
        if (rst)
            std_r <= `CDTWP_STD_RESET;
        else if (wr_std)
            std_r <= pwdata[15:0];
    end

    // rate and role load on every command write, soft reset included; rate is low after power-on
    always_ff @(posedge clk) begin
        if (rst) begin
            rate_r <= 1'b0;
            role_r <= 1'b0;
        end else if (wr_cmd) begin
            rate_r <= pwdata[`CDTWP_BIT_RATE];
            role_r <= pwdata[`CDTWP_BIT_ROLE];
        end
    end

    // selected pins pass two flops before any logic reads them
    always_ff @(posedge clk) begin
        if (rst) begin
            sda_s_r <= 2'b11;
            scl_s_r <= 2'b11;
            scl_d_r <= 1'b1;
        end else begin
            sda_s_r <= {sda_s_r[0], std_r[`CDTWP_BIT_PINSEL] ?
                        alt_data_pin_i : primary_data_pin_i};
            scl_s_r <= {scl_s_r[0], std_r[`CDTWP_BIT_PINSEL] ?
                        alt_clock_pin_i : primary_clock_pin_i};
            scl_d_r <= scl_s_r[1];
        end
    end
    assign sda_in = sda_s_r[1];
    assign scl_in = scl_s_r[1];

    // quarter-bit divider gives one-cycle ticks for master timing
    always_ff @(posedge clk) begin
        if (rst || st_r == ST_IDLE)
            cnt_r <= 16'h0;
        else if (tick)
            cnt_r <= 16'h0;
        else
            cnt_r <= cnt_r + 16'h1;
    end
    assign tick = cnt_r == (rate_r ? HI_Q : LO_Q) - 16'h1;

    // command engine: every bit is nbit_r-counted over the shifter
    always_ff @(posedge clk) begin
        if (rst || soft_rst) begin
            st_r     <= ST_IDLE;
            busy_r   <= 1'b0;
            sda_lo_r <= 1'b0;
            scl_lo_r <= 1'b0;
            ph_r     <= 2'd0;
            nbit_r   <= 4'd0;
            sh_r     <= 9'h1ff;
            rxmode_r <= 1'b0;
            rxnext_r <= 1'b0;
            rx_r     <= 8'h0;
            own_r    <= 8'h0;
            mack_r   <= 1'b1;
            cmd_r    <= 4'h0;
        end else if (wr_cmd && st_r == ST_IDLE) begin
            cmd_r  <= pwdata[15:12];
            busy_r <= 1'b1;
            ph_r   <= 2'd0;
            unique case (pwdata[15:12])
                CDTWP_CMD_START: begin
                    st_r <= role_r ? ST_IDLE : ST_START;
                    busy_r <= ~role_r;
                    sh_r <= {pwdata[7:0], 1'b1};
                    // a read address leaves its ack slot to the 1100 code
                    nbit_r <= pwdata[0] ? 4'd8 : 4'd9;
                    rxmode_r <= 1'b0;
                end
                CDTWP_CMD_SEND: begin
                    st_r <= ST_BIT;
                    sh_r <= {pwdata[7:0], 1'b1};
                    nbit_r <= 4'd9;
                    rxmode_r <= 1'b0;
                end
                CDTWP_CMD_ACKRX: begin
                    st_r <= ST_BIT;
                    sh_r <= {role_r ? 1'b0 : pwdata[7], 8'hff};
                    // ack bit alone; the byte after it is the reload
                    nbit_r <= 4'd1;
                    rxmode_r <= ~role_r;
                    rxnext_r <= 1'b1;
                end
                CDTWP_CMD_ACKEND: begin
                    st_r <= role_r ? ST_IDLE : ST_BIT;
                    busy_r <= ~role_r;
                    sh_r <= {pwdata[7], 8'hff};
                    nbit_r <= 4'd1;
                    rxmode_r <= 1'b0;
                end
                CDTWP_CMD_SADDR: begin
                    own_r <= pwdata[7:0];
                    st_r <= ST_IDLE;
                    busy_r <= 1'b0;
                end
                CDTWP_CMD_RXACK: begin
                    st_r <= role_r ? ST_IDLE : ST_BIT;
                    busy_r <= ~role_r;
                    sh_r <= 9'h1ff;
                    nbit_r <= 4'd1;
                    rxmode_r <= 1'b1;
                    rxnext_r <= 1'b0;
                end
                CDTWP_CMD_STOP: begin
                    st_r <= role_r ? ST_BIT : ST_STOP;
                    sh_r <= {role_r & ~rxmode_r ? 1'b1 : pwdata[7], 8'hff};
                    nbit_r <= 4'd1;
                    rxmode_r <= 1'b0;
                end
                default: begin  // reserved codes do nothing
                    st_r <= ST_IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end else if (st_r != ST_IDLE && role_r) begin
            // slave: drive on scl low, sample on scl rise
            if (!scl_in && scl_d_r)
                sda_lo_r <= ~sh_r[8];
            else if (scl_in && !scl_d_r) begin
                sh_r <= {sh_r[7:0], sda_in};
                nbit_r <= nbit_r - 4'd1;
                if (nbit_r == 4'd1) begin
                    mack_r <= sda_in;
                    rx_r <= sh_r[7:0];
                    st_r <= ST_IDLE;
                    busy_r <= 1'b0;
                end
            end
        end else if (tick) begin
            ph_r <= ph_r + 2'd1;
            unique case (st_r)
                ST_START: begin
                    // sda falls while scl high, then scl falls
                    if (ph_r == 2'd1)
                        sda_lo_r <= 1'b1;
                    if (ph_r == 2'd3) begin
                        scl_lo_r <= 1'b1;
                        st_r <= ST_BIT;
                    end
                end
                ST_BIT: begin
                    if (ph_r == 2'd0)
                        sda_lo_r <= ~sh_r[8];
                    if (ph_r == 2'd1)
                        scl_lo_r <= 1'b0;
                    if (ph_r == 2'd2 && scl_in) begin
                        sh_r <= {sh_r[7:0], sda_in};
                        nbit_r <= nbit_r - 4'd1;
                    end
                    if (ph_r == 2'd2 && !scl_in)
                        ph_r <= ph_r;  // clock stretched
                    if (ph_r == 2'd3) begin
                        scl_lo_r <= 1'b1;
                        if (nbit_r == 4'd0) begin
                            // sent bytes must not clobber the last rx byte
                            if (rxmode_r)
                                rx_r <= sh_r[7:0];
                            if (cmd_r == CDTWP_CMD_RXACK && !sh_r[0]) begin
                                sh_r <= 9'h1ff;  // ack low, read byte
                                nbit_r <= 4'd8;
                                cmd_r <= CDTWP_CMD_SEND;
                            end else if (rxnext_r) begin
                                rxnext_r <= 1'b0;
                                sh_r <= 9'h1ff;
                                nbit_r <= 4'd8;
                            end else begin
                                st_r <= ST_IDLE;
                                busy_r <= 1'b0;
                            end
                        end
                    end
                end
                ST_STOP: begin
                    // sda low, scl released, then sda released
                    if (ph_r == 2'd0)
                        sda_lo_r <= 1'b1;
                    if (ph_r == 2'd1)
                        scl_lo_r <= 1'b0;
                    if (ph_r == 2'd3) begin
                        sda_lo_r <= 1'b0;
                        st_r <= ST_IDLE;
                        busy_r <= 1'b0;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // pin pair routing: unselected pair never driven
    always_comb begin
        primary_drv = '{sda_o: 1'b0, sda_oe: 1'b0, scl_o: 1'b0, scl_oe: 1'b0};
        alt_drv     = '{sda_o: 1'b0, sda_oe: 1'b0, scl_o: 1'b0, scl_oe: 1'b0};
        if (std_r[`CDTWP_BIT_PINSEL]) begin
            alt_drv.sda_oe = sda_lo_r;
            alt_drv.scl_oe = scl_lo_r;
        end else begin
            primary_drv.sda_oe = sda_lo_r;
            primary_drv.scl_oe = scl_lo_r;
        end
    end

    chk_busy_idle: assert property (@(posedge clk) disable iff (rst)
        st_r == ST_IDLE |-> !busy_r)
        else $error("busy set while idle");

    chk_rate_reset: assert property (@(posedge clk)
        $fell(rst) |-> !rate_r)
        else $error("rate not low after reset");

    chk_soft_reset: assert property (@(posedge clk) disable iff (rst)
        soft_rst |=> st_r == ST_IDLE && !busy_r)
        else $error("soft reset did not idle");

    chk_pin_route: assert property (@(posedge clk) disable iff (rst)
        std_r[`CDTWP_BIT_PINSEL] |-> !primary_drv.sda_oe)
        else $error("primary pins driven when alternate chosen");

    chk_saddr_load: assert property (@(posedge clk) disable iff (rst)
        wr_cmd && st_r == ST_IDLE && pwdata[15:12] == 4'h9 &&
        !pwdata[11] |=> own_r == $past(pwdata[7:0]))
        else $error("own address not loaded");

    chk_start_busy: assert property (@(posedge clk) disable iff (rst)
        wr_cmd && st_r == ST_IDLE && pwdata[15:12] == 4'h0 &&
        !role_r && !pwdata[11] |=> busy_r && st_r == ST_START)
        else $error("start not begun");

    // state has already left stop when busy is seen low, so look back
    chk_stop_end: assert property (@(posedge clk) disable iff (rst)
        $fell(busy_r) && $past(st_r) == ST_STOP |->
        !sda_lo_r && !scl_lo_r)
        else $error("stop left lines low");

    chk_cmd_reads0: assert property (@(posedge clk) disable iff (rst)
        psel && penable && paddr == `CDTWP_OFF_CMD |->
        prdata[15:11] == 5'h0)
        else $error("command field not read as zero");

    // a legal send command is taken from idle
    sequence seq_send_taken;
        wr_cmd && st_r == ST_IDLE && pwdata[15:12] == 4'h2 &&
        !pwdata[11];
    endsequence

    // the engine then shifts with busy raised
    sequence seq_send_running;
        busy_r && st_r == ST_BIT && nbit_r == 4'd9;
    endsequence

    chk_send_busy: assert property (@(posedge clk) disable iff (rst)
        seq_send_taken |=> seq_send_running)
        else $error("send not begun");

    chk_rate_write: assert property (@(posedge clk) disable iff (rst)
        wr_cmd |=> rate_r == $past(pwdata[`CDTWP_BIT_RATE]))
        else $error("rate bit not taken");

    chk_rd_addr: assert property (@(posedge clk) disable iff (rst)
        wr_cmd && st_r == ST_IDLE && pwdata[15:12] == 4'h0 &&
        !role_r && !pwdata[11] && pwdata[0] |=>
        nbit_r == 4'd8)
        else $error("read address not eight bits");

    // the alternate pair stays quiet while the primary is chosen
    chk_alt_quiet: assert property (@(posedge clk) disable iff (rst)
        !std_r[`CDTWP_BIT_PINSEL] |->
        !alt_drv.sda_oe && !alt_drv.scl_oe)
        else $error("alternate pins driven when primary chosen");
endmodule  // cdtwp_port

// ### core/cdtwp_defs.svh
/*
 * offsets, field positions, reset values and timing counts of the
 * two-wire command port. assumes a 100 MHz system clock.
 */
`ifndef CDTWP_DEFS_SVH
`define CDTWP_DEFS_SVH

`define CDTWP_OFF_CMD      12'h000
`define CDTWP_OFF_STD      12'h004
`define CDTWP_BIT_RESET    11
`define CDTWP_BIT_RATE     10
`define CDTWP_BIT_ROLE     9
`define CDTWP_BIT_BUSY     8
`define CDTWP_BIT_PINSEL   8
`define CDTWP_STD_RESET    16'h0000
`define CDTWP_CLK_HZ       100000000
`define CDTWP_LO_HZ        100000
`define CDTWP_HI_HZ        400000
// quarter-period counts of the bus clock, rounded down
`define CDTWP_LO_QTR       (`CDTWP_CLK_HZ / (4 * `CDTWP_LO_HZ))
`define CDTWP_HI_QTR       (`CDTWP_CLK_HZ / (4 * `CDTWP_HI_HZ))

`endif

// ### core/cdtwp_pkg.sv
/*
 * types of the two-wire command port.
 * assumes cdtwp_defs.svh holds the numbers.
 */
package cdtwp_pkg;
    typedef enum logic [3:0] {
        CDTWP_CMD_START  = 4'h0,
        CDTWP_CMD_SEND   = 4'h2,
        CDTWP_CMD_ACKRX  = 4'h4,
        CDTWP_CMD_ACKEND = 4'h6,
        CDTWP_CMD_SADDR  = 4'h9,
        CDTWP_CMD_RXACK  = 4'hc,
        CDTWP_CMD_STOP   = 4'he
    } cdtwp_cmd_t;

    typedef struct packed {
        logic sda_o;
        logic sda_oe;
        logic scl_o;
        logic scl_oe;
    } cdtwp_drv_t;
endpackage

// ### verif/cdtwp_bus_partner.sv
/* addressed slave on the primary pin pair of the two-wire port.
   assumes open-drain lines with pull-ups, sampled on the bench clock. */
`timescale 1ns/100ps
module cdtwp_bus_partner #(
    parameter logic [7:0] TX_FIRST = 8'hc3
) (
    input  wire logic       clk,
    input  wire logic       scl,
    input  wire logic       sda,
    output logic            sda_oe,
    output logic [7:0]      rx_byte
);
    logic       scl_q, sda_q, rd_r, first_r, nak_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r, tx_r;
    initial begin
        {sda_oe, rx_byte, sh_r, cnt_r, rd_r, first_r, nak_r} = '0;
        {scl_q, sda_q} = 2'b11;
        tx_r = TX_FIRST;
    end
    // frame tracking; released line floats back to the pull-up level
    always @(posedge clk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (scl && scl_q && sda_q && !sda) begin
            {cnt_r, rd_r, nak_r} <= '0;
            first_r <= 1'b1;
        end else if (scl && scl_q && !sda_q && sda) begin
            sda_oe <= 1'b0;
            first_r <= 1'b0;
        end else if (scl && !scl_q) begin
            if (cnt_r < 8)
                sh_r <= {sh_r[6:0], sda};
            else if (rd_r && !first_r) begin
                nak_r <= sda;
                tx_r <= tx_r + 8'h01;
            end
            cnt_r <= cnt_r + 4'h1;
        end else if (!scl && scl_q) begin
            if (cnt_r == 8) begin
                // ack address and written bytes; free the line for the
                // master's own ack after a byte we sent
                sda_oe <= first_r || !rd_r;
                if (first_r || !rd_r)
                    rx_byte <= sh_r;
                if (first_r)
                    rd_r <= sh_r[0];
            end else if (cnt_r == 9) begin
                cnt_r <= 4'h0;
                first_r <= 1'b0;
                sda_oe <= rd_r && !nak_r && !tx_r[7];
            end else if (rd_r && !first_r && !nak_r)
                sda_oe <= !tx_r[3'd7 - cnt_r[2:0]];
        end
    end
endmodule // cdtwp_bus_partner

// ### verif/test_command_driven_two_wire_port.sv
/* self-checking bench of the two-wire command port.
   assumes the defs header on the include path and the bus partner. */
`timescale 1ns/100ps
`include "cdtwp_defs.svh"
module test_command_driven_two_wire_port
    import cdtwp_pkg::*;
;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] w;
        logic [31:0] q;
        logic        e;
    } cdtwp_row_t;
    cdtwp_row_t rows [6] = '{
        '{12'h004, 32'h0100, 32'h0100, 1'b0},
        '{12'h004, 32'h0000, 32'h0000, 1'b0},
        '{12'h000, 32'h945a, 32'h0400, 1'b0},
        '{12'h000, 32'h9e5a, 32'h0600, 1'b0},
        '{12'h000, 32'h9000, 32'h0000, 1'b0},
        '{12'h008, 32'h0000, 32'h0000, 1'b1}};
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, cyc = 0, per = 0;
    logic        pready, pslverr, er, part_oe, scl_d = 1;
    logic        prim_act = 0, alt_act = 0;
    logic [7:0]  part_rx;
    cdtwp_drv_t  primary_drv, alt_drv;
    int          err_count = 0, check_count = 0;
    wire logic   p_scl = ~primary_drv.scl_oe;
    wire logic   p_sda = ~(primary_drv.sda_oe | part_oe);
    wire logic   a_scl = ~alt_drv.scl_oe;
    wire logic   a_sda = ~alt_drv.sda_oe;

    always #5 clk = ~clk;
    cdtwp_port uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .primary_data_pin_i(p_sda),
        .primary_clock_pin_i(p_scl), .alt_data_pin_i(a_sda),
        .alt_clock_pin_i(a_scl), .primary_drv(primary_drv),
        .alt_drv(alt_drv));
    cdtwp_bus_partner #(.TX_FIRST(8'hc3)) partner (.clk(clk), .scl(p_scl),
        .sda(p_sda), .sda_oe(part_oe), .rx_byte(part_rx));

    // bus clock period, fall to fall, and which pin pair ever moved
    always @(posedge clk) begin
        scl_d <= p_scl;
        cyc <= (scl_d && !p_scl) ? 32'h0 : cyc + 32'h1;
        if (scl_d && !p_scl)
            per <= cyc + 32'h1;
        if (primary_drv.sda_oe || primary_drv.scl_oe)
            prim_act <= 1'b1;
        if (alt_drv.sda_oe || alt_drv.scl_oe)
            alt_act <= 1'b1;
    end

    task end_of_test;
        $display("errors %0d of %0d checks", err_count, check_count);
        if (err_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, then an idle cycle so strobes never toggle twice
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
        if (n >= 100) begin
            err_count++;
            end_of_test();
        end
    endtask
    // poll busy; the data field is only trusted once it has cleared
    task wait_idle;
        int n;
        n = 0;
        do begin
            apb(12'h000, 1'b0, 32'h0);
            n++;
        end while (rd[8] !== 1'b0 && n < 20000);
        if (n >= 20000) begin
            err_count++;
            end_of_test();
        end
    endtask
    task cmd(input logic [3:0] c, input logic r, input logic [7:0] d);
        apb(12'h000, 1'b1, {16'h0, c, 1'b0, r, 2'b00, d});
        wait_idle();
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        apb(12'h000, 1'b0, 32'h0);
        check(rd, 32'h0);
        // rows use only codes legal in either role
        foreach (rows[i]) begin
            apb(rows[i].a, 1'b1, rows[i].w);
            apb(rows[i].a, 1'b0, 32'h0);
            check(rd, rows[i].q);
            check(er, rows[i].e);
        end
        // write frame at high speed
        apb(12'h000, 1'b1, {16'h0, CDTWP_CMD_START, 4'h4, 8'ha4});
        apb(12'h000, 1'b0, 32'h0);
        check(rd[8], 1'b1);
        wait_idle();
        check(part_rx, 8'ha4);
        cmd(CDTWP_CMD_SEND, 1'b1, 8'h3c);
        check(part_rx, 8'h3c);
        check(per, 4 * `CDTWP_HI_QTR);
        cmd(CDTWP_CMD_STOP, 1'b1, 8'h00);
        check({p_scl, p_sda}, 2'b11);
        // read frame at low speed, two bytes, ack then nak
        cmd(CDTWP_CMD_START, 1'b0, 8'ha5);
        cmd(CDTWP_CMD_RXACK, 1'b0, 8'h00);
        check(rd[7:0], 8'hc3);
        cmd(CDTWP_CMD_ACKRX, 1'b0, 8'h00);
        check(rd[7:0], 8'hc4);
        check(per, 4 * `CDTWP_LO_QTR);
        cmd(CDTWP_CMD_ACKEND, 1'b0, 8'h80);
        check(rd[8], 1'b0);
        check(rd[7:0], 8'hc4);
        cmd(CDTWP_CMD_STOP, 1'b0, 8'h00);
        check({p_scl, p_sda}, 2'b11);
        // alternate pin pair only
        apb(12'h004, 1'b1, 32'h0100);
        prim_act = 0;
        alt_act = 0;
        cmd(CDTWP_CMD_START, 1'b1, 8'h44);
        cmd(CDTWP_CMD_STOP, 1'b1, 8'h00);
        check(prim_act, 1'b0);
        check(alt_act, 1'b1);
        apb(12'h004, 1'b1, 32'h0);
        // soft reset during the start condition, before sda falls, leaves the lines released
        apb(12'h000, 1'b1, {16'h0, CDTWP_CMD_START, 4'h4, 8'ha4});
        repeat (100) @(posedge clk);
        apb(12'h000, 1'b1, 32'h0c00);
        apb(12'h000, 1'b0, 32'h0);
        check(rd, 32'h0400);
        check(primary_drv, 4'h0);
        // hardware reset during the start condition, before sda falls
        apb(12'h000, 1'b1, {16'h0, CDTWP_CMD_START, 4'h4, 8'ha4});
        repeat (100) @(posedge clk);
        rst <= 1;
        repeat (3) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        check(primary_drv, 4'h0);
        apb(12'h000, 1'b0, 32'h0);
        check(rd, 32'h0);
        end_of_test();
    end
endmodule // test_command_driven_two_wire_port
